// ---- design/ccvd_pkg.sv ----
// Constants shared by the CC and VBUS connection detection logic.
// Assumes one 100 MHz system clock and a 20 kHz keep-alive rate made by division.
package ccvd_pkg;

  // ****************************************
  // Clocking
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;       // System clock period
  localparam int KA_PERIOD_NS  = 50000;    // Keep-alive period (20 kHz)
  localparam int KA_DIV_CYCLES = KA_PERIOD_NS / CLK_PERIOD_NS;

  // ****************************************
  // Widths and threshold positions
  // ****************************************
  localparam int CC_THR_W      = 7;        // Thresholds per CC pin
  localparam int VB_THR_W      = 2;        // VBUS present, VBUS safe-zero
  localparam int CNT_W         = 16;       // Debounce and timeout counters
  localparam int VB_PRESENT_IDX = 0;
  localparam int VB_SAFE0_IDX   = 1;
  localparam int OPEN_DEF_IDX   = 1;       // open_threshold_default
  localparam int OPEN_MID_IDX   = 5;       // open_threshold_mid
  localparam int OPEN_HIGH_IDX  = 6;       // open_threshold_high

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] LC_OFF  = 2'h0;   // line_control: no sampling
  localparam logic [1:0] LC_PIN1 = 2'h1;
  localparam logic [1:0] LC_PIN2 = 2'h2;
  localparam logic [1:0] ADV_DEF = 2'h1;   // Advertised level codes
  localparam logic [1:0] ADV_MID = 2'h2;
  localparam logic [1:0] ADV_HIGH = 2'h3;

  // Discharge sequencer states
  typedef enum logic [1:0] {DS_IDLE, DS_CLOSED} ccvd_ds_t;

  // Counter reaches its programmed limit on the next step
  function automatic logic ccvd_reached(input logic [CNT_W-1:0] cnt,
                                        input logic [CNT_W-1:0] lim);
    ccvd_reached = ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
  endfunction

endpackage

// ---- design/ccvd_dbnc_if.sv ----
// Carrier between the detection core and one threshold debouncer.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
interface ccvd_dbnc_if #(parameter int W = 7);
  logic         enable;      // Debouncer on
  logic         tick;        // Keep-alive sample pulse
  logic [15:0]  limit;       // Debounce length in ticks
  logic [W-1:0] bit_en;      // Thresholds taking part
  logic [W-1:0] raw;         // Comparator outputs
  logic [W-1:0] stable;      // Debounced match
  logic [W-1:0] changed;     // One-cycle change pulses
  logic         first_done;  // First window complete
  logic         active;      // Running flag

  modport ctrl (output enable, tick, limit, bit_en, raw,
                input stable, changed, first_done, active);
  modport core (input enable, tick, limit, bit_en, raw,
                output stable, changed, first_done, active);
endinterface

// ---- design/ccvd_dbnc.sv ----
// Per-threshold debouncer for one group of comparator outputs.
// Assumes tick is a one-cycle pulse at the keep-alive rate.
`timescale 1ns/100ps
module ccvd_dbnc #(
  parameter int W = 7
) (
  input  wire logic  clk_sys,
  input  wire logic  rstn,
  ccvd_dbnc_if.core  dbi
);

  logic [ccvd_pkg::CNT_W-1:0] cnt_q [W];  // Per-threshold run length
  logic [ccvd_pkg::CNT_W-1:0] win_q;      // First window length
  logic [W-1:0]               stable_q;   // Debounced values
  logic [W-1:0]               changed_q;  // Change pulses
  logic                       first_q;    // First window done
  logic                       active_q;   // Running flag

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ****************************************
  // First window
  // ****************************************
  // Counts one whole interval before the match is declared valid
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      win_q   <= '0;
      first_q <= 1'b0;
    end else if (!dbi.enable) begin
      win_q   <= '0;
      first_q <= 1'b0;
    end else if (dbi.tick && !first_q) begin
      win_q <= win_q + 16'h0001;
      if (ccvd_pkg::ccvd_reached(win_q, dbi.limit)) begin
        first_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Threshold debounce
  // ****************************************
  // Each threshold keeps its own count so one noisy line never holds another
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stable_q  <= '0;
      changed_q <= '0;
      for (int i = 0; i < W; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      changed_q <= '0;
      for (int i = 0; i < W; i++) begin
        if (!dbi.enable || !dbi.bit_en[i]) begin
          // Disabled thresholds hold their last match
          cnt_q[i] <= '0;
        end else if (dbi.tick && !first_q) begin
          // Initial load, no change reported
          if (ccvd_pkg::ccvd_reached(win_q, dbi.limit)) begin
            stable_q[i] <= dbi.raw[i];
          end
        end else if (dbi.tick && dbi.raw[i] != stable_q[i]) begin
          if (ccvd_pkg::ccvd_reached(cnt_q[i], dbi.limit)) begin
            stable_q[i]  <= dbi.raw[i];
            changed_q[i] <= 1'b1;
            cnt_q[i]     <= '0;
          end else begin
            cnt_q[i] <= cnt_q[i] + 16'h0001;
          end
        end else if (dbi.tick) begin
          // Glitch shorter than the interval is dropped
          cnt_q[i] <= '0;
        end
      end
    end
  end

  // Running flag trails the enable by one cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      active_q <= 1'b0;
    end else begin
      active_q <= dbi.enable;
    end
  end

  assign dbi.stable     = stable_q;
  assign dbi.changed    = changed_q;
  assign dbi.first_done = first_q;
  assign dbi.active     = active_q;

  // ****************************************
  // Checks
  // ****************************************
  AST_ACTIVE_RISE: assert property ($rose(dbi.enable) |=> dbi.active)
    else $error("running flag did not follow enable");
  AST_CHG_ON_TICK: assert property ((changed_q != '0) |-> $past(dbi.tick))
    else $error("change outside a keep-alive tick");
  AST_CHG_GATED: assert property ((changed_q & ~$past(dbi.bit_en)) == '0)
    else $error("change on a disabled threshold");
  AST_CHG_MOVES: assert property ((changed_q != '0) |-> stable_q != $past(stable_q))
    else $error("change reported without match update");

endmodule

// ---- design/ccvd_top.sv ----
// CC and VBUS attach and detach detection with discharge sequencing.
// Assumes comparator outputs and control levels are synchronous to clk_sys.
`timescale 1ns/100ps
module ccvd_top #(
  parameter int KA_DIV = ccvd_pkg::KA_DIV_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        host_access,                 // Bus access pulse
  input  wire logic        keepalive_only_req,          // clock_source_control
  input  wire logic [1:0]  line_control,
  input  wire logic        cc_debounce_enable,
  input  wire logic [6:0]  pin1_comparator,
  input  wire logic [6:0]  pin2_comparator,
  input  wire logic [6:0]  pin1_debounce_clear_enable,
  input  wire logic [6:0]  pin2_debounce_clear_enable,
  input  wire logic [15:0] match_debounce_time,
  input  wire logic        bus_power_control,           // VBUS comparator on
  input  wire logic        vbus_present_comparator,
  input  wire logic        vbus_safe0_comparator,
  input  wire logic [15:0] bus_power_debounce_time,
  input  wire logic [15:0] discharge_timeout,
  input  wire logic        port_power_controller_en,
  input  wire logic        discharge_request,           // Pulse after detach
  input  wire logic        role_sink,
  input  wire logic [1:0]  advertised_level,
  input  wire logic [2:0]  line_interrupt_enable,       // pin1, pin2, valid
  input  wire logic [1:0]  power_interrupt_enable,      // valid, error
  input  wire logic [2:0]  summary_interrupt_enable,    // cc, vbus, power
  input  wire logic [6:0]  pin1_change_clear,
  input  wire logic [6:0]  pin2_change_clear,
  input  wire logic [1:0]  bus_power_change_clear,
  input  wire logic        discharge_error_clear,
  output logic [6:0]       pin1_threshold_match,
  output logic [6:0]       pin2_threshold_match,
  output logic [6:0]       pin1_change_status,
  output logic [6:0]       pin2_change_status,
  output logic             pin1_match_change_irq,
  output logic             pin2_match_change_irq,
  output logic             config_line_match_valid,
  output logic             config_line_summary_irq,
  output logic [1:0]       bus_power_threshold_match,
  output logic [1:0]       bus_power_change_status,
  output logic             bus_power_match_valid,
  output logic             bus_power_summary_irq,
  output logic             power_summary_irq,
  output logic             cc_debouncer_running_flag,
  output logic             vbus_debouncer_running_flag,
  output logic             source_detach,
  output logic             sink_pulldown_en,
  output logic             source_connected,
  output logic             hs_osc_on,
  output logic             power_switch_closed,
  output logic             discharge_switch_closed,
  output logic             discharge_error,
  output logic             irq_n
);

  logic [12:0]                ka_cnt_q;        // Keep-alive divider
  logic                       ka_tick_q;       // Keep-alive pulse
  logic                       osc_q;           // Fast oscillator running
  logic                       psw_q;           // VBUS power switch
  ccvd_pkg::ccvd_ds_t         ds_q;            // Discharge sequencer
  logic [ccvd_pkg::CNT_W-1:0] ds_cnt_q;        // Discharge time used
  logic                       derr_q;          // Discharge error sticky
  logic [6:0]                 chg1_q;          // Pin 1 change sticky
  logic [6:0]                 chg2_q;          // Pin 2 change sticky
  logic [1:0]                 vchg_q;          // VBUS change sticky
  logic                       irq_n_q;         // Interrupt pin
  logic                       open_hit;        // Monitored pin over vOPEN
  logic [6:0]                 mon_match;       // Match of monitored pin

  ccvd_dbnc_if #(.W(ccvd_pkg::CC_THR_W)) cc1_if ();
  ccvd_dbnc_if #(.W(ccvd_pkg::CC_THR_W)) cc2_if ();
  ccvd_dbnc_if #(.W(ccvd_pkg::VB_THR_W)) vb_if ();

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ****************************************
  // Keep-alive divider
  // ****************************************
  // Debouncer sampling and the discharge timeout run on this pulse so the fast clock may stop meanwhile
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ka_cnt_q  <= '0;
      ka_tick_q <= 1'b0;
    end else if (ka_cnt_q == 13'(KA_DIV - 1)) begin
      ka_cnt_q  <= '0;
      ka_tick_q <= 1'b1;
    end else begin
      ka_cnt_q  <= ka_cnt_q + 13'h0001;
      ka_tick_q <= 1'b0;
    end
  end

  // ****************************************
  // Debouncers
  // ****************************************
  // Pin debouncers run only for pins selected by line_control
  assign cc1_if.enable = cc_debounce_enable && line_control[0];
  assign cc2_if.enable = cc_debounce_enable && line_control[1];
  assign cc1_if.tick   = ka_tick_q;
  assign cc2_if.tick   = ka_tick_q;
  assign cc1_if.limit  = match_debounce_time;
  assign cc2_if.limit  = match_debounce_time;
  assign cc1_if.bit_en = pin1_debounce_clear_enable;
  assign cc2_if.bit_en = pin2_debounce_clear_enable;
  assign cc1_if.raw    = pin1_comparator;
  assign cc2_if.raw    = pin2_comparator;
  assign vb_if.enable  = bus_power_control;
  assign vb_if.tick    = ka_tick_q;
  assign vb_if.limit   = bus_power_debounce_time;
  assign vb_if.bit_en  = 2'h3;
  assign vb_if.raw     = {vbus_safe0_comparator, vbus_present_comparator};

  ccvd_dbnc #(.W(ccvd_pkg::CC_THR_W)) u_cc1 (.clk_sys(clk_sys), .rstn(rstn), .dbi(cc1_if));
  ccvd_dbnc #(.W(ccvd_pkg::CC_THR_W)) u_cc2 (.clk_sys(clk_sys), .rstn(rstn), .dbi(cc2_if));
  ccvd_dbnc #(.W(ccvd_pkg::VB_THR_W)) u_vb  (.clk_sys(clk_sys), .rstn(rstn), .dbi(vb_if));

  // ****************************************
  // Sticky change status
  // ****************************************
  // A new change in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chg1_q <= '0;
      chg2_q <= '0;
      vchg_q <= '0;
    end else begin
      chg1_q <= (chg1_q & ~pin1_change_clear) | cc1_if.changed;
      chg2_q <= (chg2_q & ~pin2_change_clear) | cc2_if.changed;
      vchg_q <= (vchg_q & ~bus_power_change_clear) | vb_if.changed;
    end
  end

  // ****************************************
  // Source detach and sink attach
  // ****************************************
  // Monitored pin is the single one sampled; both-pin mode is attach only
  always_comb begin
    mon_match = (line_control == ccvd_pkg::LC_PIN2) ? cc2_if.stable : cc1_if.stable;
    unique case (advertised_level)
      ccvd_pkg::ADV_DEF:  open_hit = mon_match[ccvd_pkg::OPEN_DEF_IDX];
      ccvd_pkg::ADV_MID:  open_hit = mon_match[ccvd_pkg::OPEN_MID_IDX];
      ccvd_pkg::ADV_HIGH: open_hit = mon_match[ccvd_pkg::OPEN_HIGH_IDX];
      default:            open_hit = 1'b0;                  // No advertisement
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      source_detach    <= 1'b0;
      sink_pulldown_en <= 1'b0;
      source_connected <= 1'b0;
    end else begin
      source_detach    <= !role_sink && open_hit
                          && (line_control == ccvd_pkg::LC_PIN1
                              || line_control == ccvd_pkg::LC_PIN2);
      sink_pulldown_en <= role_sink;
      source_connected <= role_sink && vb_if.stable[ccvd_pkg::VB_PRESENT_IDX];
    end
  end

  // ****************************************
  // Oscillator and power switch
  // ****************************************
  // Wake wins over the stop request; stop waits for a finished discharge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      osc_q <= 1'b0;
    end else if (host_access) begin
      osc_q <= 1'b1;
    end else if (keepalive_only_req && ds_q == ccvd_pkg::DS_IDLE) begin
      osc_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      psw_q <= 1'b0;
    end else begin
      psw_q <= port_power_controller_en;
    end
  end

  // ****************************************
  // Discharge sequencer
  // ****************************************
  // Timeout counts keep-alive ticks; switch opens on safe level or error
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ds_q     <= ccvd_pkg::DS_IDLE;
      ds_cnt_q <= '0;
    end else begin
      unique case (ds_q)
        ccvd_pkg::DS_IDLE: begin
          ds_cnt_q <= '0;
          if (discharge_request && !port_power_controller_en) begin
            ds_q <= ccvd_pkg::DS_CLOSED;
          end
        end
        ccvd_pkg::DS_CLOSED: begin
          if (vbus_safe0_comparator) begin
            ds_q <= ccvd_pkg::DS_IDLE;
          end else if (ka_tick_q) begin
            ds_cnt_q <= ds_cnt_q + 16'h0001;
            if (ccvd_pkg::ccvd_reached(ds_cnt_q, discharge_timeout)) begin
              ds_q <= ccvd_pkg::DS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Error stays until cleared; a new error beats the clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      derr_q <= 1'b0;
    end else if (ds_q == ccvd_pkg::DS_CLOSED && !vbus_safe0_comparator && ka_tick_q
                 && ccvd_pkg::ccvd_reached(ds_cnt_q, discharge_timeout)) begin
      derr_q <= 1'b1;
    end else if (discharge_error_clear) begin
      derr_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt combination
  // ****************************************
  assign pin1_match_change_irq   = (|chg1_q) && line_interrupt_enable[0];
  assign pin2_match_change_irq   = (|chg2_q) && line_interrupt_enable[1];
  assign config_line_match_valid = cc1_if.first_done && cc2_if.first_done;
  assign config_line_summary_irq = pin1_match_change_irq || pin2_match_change_irq
                                   || (config_line_match_valid && line_interrupt_enable[2]);
  assign bus_power_match_valid   = vb_if.first_done;
  assign bus_power_summary_irq   = |vchg_q;
  assign power_summary_irq       = (bus_power_match_valid && power_interrupt_enable[0])
                                   || (derr_q && power_interrupt_enable[1]);

  // Pin is low while any enabled summary is pending
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !((config_line_summary_irq && summary_interrupt_enable[0])
                   || (bus_power_summary_irq && summary_interrupt_enable[1])
                   || (power_summary_irq && summary_interrupt_enable[2]));
    end
  end

  assign pin1_threshold_match        = cc1_if.stable;
  assign pin2_threshold_match        = cc2_if.stable;
  assign pin1_change_status          = chg1_q;
  assign pin2_change_status          = chg2_q;
  assign bus_power_threshold_match   = vb_if.stable;
  assign bus_power_change_status     = vchg_q;
  assign cc_debouncer_running_flag   = cc1_if.active || cc2_if.active;
  assign vbus_debouncer_running_flag = vb_if.active;
  assign hs_osc_on                   = osc_q;
  assign power_switch_closed         = psw_q;
  assign discharge_switch_closed     = (ds_q == ccvd_pkg::DS_CLOSED);
  assign discharge_error             = derr_q;
  assign irq_n                       = irq_n_q;

  // ****************************************
  // Checks
  // ****************************************
  AST_OSC_WAKE: assert property (host_access |=> hs_osc_on)
    else $error("oscillator not started by host access");
  AST_OSC_STOP: assert property (keepalive_only_req && !host_access && !discharge_switch_closed
                                 |=> !hs_osc_on)
    else $error("oscillator still running when idle");
  AST_PPC_OFF: assert property (!port_power_controller_en |=> !power_switch_closed)
    else $error("power switch closed with controller off");
  AST_DISCH_END: assert property (discharge_switch_closed && vbus_safe0_comparator
                                  |=> !discharge_switch_closed)
    else $error("discharge switch held past safe level");
  AST_DISCH_ERR: assert property ($rose(discharge_error) |-> $past(discharge_switch_closed)
                                  && !discharge_switch_closed)
    else $error("discharge error without a timed out discharge");
  AST_IRQ_CC: assert property (config_line_summary_irq && summary_interrupt_enable[0]
                               |=> !irq_n)
    else $error("cc summary did not pull interrupt pin");
  AST_IRQ_FREE: assert property (!config_line_summary_irq && !bus_power_summary_irq
                                 && !power_summary_irq |=> irq_n)
    else $error("interrupt pin low with nothing pending");
  AST_CHG_HOLD: assert property (pin1_change_clear == '0 |=>
                                 (chg1_q & $past(chg1_q)) == $past(chg1_q))
    else $error("change status lost without a clear");
  AST_VB_CHG: assert property ($rose(|vchg_q) |-> $past(vb_if.changed != '0))
    else $error("vbus change status set without debounced change");
  AST_DETACH_SRC: assert property (role_sink |=> !source_detach)
    else $error("source detach flagged in sink role");

endmodule

// ---- tb/ccvd_partner.sv ----
// Far side model: comparator levels and a VBUS rail that bleeds only through discharge.
// Assumes the bench sets the wanted CC levels and VBUS presence.
`timescale 1ns/100ps
module ccvd_partner (
  input  wire logic       clk_sys, rstn, vbus_on, discharge_switch_closed,
  input  wire logic [6:0] p1_lvl, p2_lvl,
  input  wire logic [3:0] decay,                // 0 = rail never bleeds
  output logic [6:0]      pin1_comparator, pin2_comparator,
  output logic            vbus_present_comparator, vbus_safe0_comparator
);
  logic       rail_q;                           // Rail above safe-zero
  logic [3:0] cnt_q;
  // Comparators settle one cycle after the line moves
  always_ff @(posedge clk_sys) begin
    pin1_comparator <= p1_lvl;
    pin2_comparator <= p2_lvl;
    vbus_present_comparator <= vbus_on;
  end
  // Rail holds charge until the discharge switch drains it
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) begin
      rail_q <= 1'b0;
      cnt_q  <= 4'h0;
    end else if (vbus_on) begin
      rail_q <= 1'b1;
      cnt_q  <= 4'h0;
    end else if (discharge_switch_closed && decay != 4'h0) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q + 4'h1 >= decay) rail_q <= 1'b0;
    end
  assign vbus_safe0_comparator = !rail_q;
endmodule

// ---- tb/tb_ccvd_top.sv ----
// Bench for ccvd_top: random CC patterns, VBUS and discharge runs.
// Assumes the partner model drives every comparator input.
`timescale 1ns/100ps
`define CHK(a,b) begin compares++; if ((a)!==(b)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_ccvd_top;
  logic clk_sys=0, rstn=0, host_access=0, keepalive_only_req=0, cc_debounce_enable=0;
  logic bus_power_control=0, port_power_controller_en=0, discharge_request=0, role_sink=0;
  logic discharge_error_clear=0, vbus_on=0, vbus_present_comparator, vbus_safe0_comparator;
  logic [1:0] line_control=0, advertised_level=2'h3, power_interrupt_enable=2'h2;
  logic [1:0] bus_power_change_clear=0, bus_power_threshold_match, bus_power_change_status;
  logic [2:0] line_interrupt_enable=3'h3, summary_interrupt_enable=3'h7;
  logic [3:0] decay=0;
  logic [6:0] p1_lvl=0, p2_lvl=0, pin1_comparator, pin2_comparator, exp1=0, st=0;
  logic [6:0] pin1_debounce_clear_enable=7'h7f, pin2_debounce_clear_enable=7'h7f;
  logic [6:0] pin1_change_clear=0, pin2_change_clear=0, pin1_threshold_match;
  logic [6:0] pin2_threshold_match, pin1_change_status, pin2_change_status;
  logic [15:0] match_debounce_time=16'h2, bus_power_debounce_time=16'h2;
  logic [15:0] discharge_timeout=16'h3;
  logic pin1_match_change_irq, pin2_match_change_irq, config_line_match_valid, irq_n;
  logic config_line_summary_irq, bus_power_match_valid, bus_power_summary_irq, hs_osc_on;
  logic power_summary_irq, cc_debouncer_running_flag, vbus_debouncer_running_flag;
  logic source_detach, sink_pulldown_en, source_connected, power_switch_closed;
  logic discharge_switch_closed, discharge_error;
  int num_errors=0, compares=0, cyc=0, i, k, seed=32'hbe59d339;
  ccvd_top #(.KA_DIV(4)) dut (.*);
  ccvd_partner partner (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic tk(input int n); repeat (n) @(posedge clk_sys); #1; endtask
  // Thresholds a random draw flips; bit 0 always moves so every round changes
  function automatic logic [6:0] flip_mask(input int r);
    return r[6:0] | 7'h01;
  endfunction
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; stop_test(); end
  end
  initial begin
    tk(8); rstn = 1;
    bus_power_control = 1; // VBUS comparator stays on throughout
    `CHK(irq_n, 1'b1)
    host_access = 1; tk(1); host_access = 0; tk(1);
    `CHK(hs_osc_on, 1'b1)
    keepalive_only_req = 1; tk(3); keepalive_only_req = 0;
    `CHK(hs_osc_on, 1'b0)
    port_power_controller_en = 1; tk(2);
    `CHK(power_switch_closed, 1'b1)
    port_power_controller_en = 0; tk(2);
    `CHK(power_switch_closed, 1'b0)
    line_control = 2'h3; cc_debounce_enable = 1; tk(2);
    `CHK(cc_debouncer_running_flag, 1'b1)
    for (k = 0; k < 300 && config_line_match_valid !== 1'b1; k++) tk(1);
    `CHK(config_line_match_valid, 1'b1)
    `CHK({bus_power_match_valid, vbus_debouncer_running_flag}, 2'h3)
    // Random toggles; status left uncleared in rounds 0 and 2 to prove it sticks
    for (i = 0; i < 4; i++) begin
      k = $random(seed); st |= flip_mask(k); exp1 ^= flip_mask(k);
      p1_lvl = exp1; p2_lvl = exp1;
      for (k = 0; k < 300 && pin1_threshold_match !== exp1; k++) tk(1);
      tk(2);
      `CHK(pin1_threshold_match, exp1)
      `CHK(pin1_change_status, st)
      `CHK({pin2_threshold_match, pin2_change_status}, {exp1, st})
      `CHK({pin1_match_change_irq, pin2_match_change_irq, config_line_summary_irq}, 3'h7)
      `CHK(irq_n, 1'b0)
      if (i[0]) begin
        pin1_change_clear = 7'h7f; pin2_change_clear = 7'h7f; tk(1);
        pin1_change_clear = 0; pin2_change_clear = 0; st = 0; tk(2);
        `CHK(irq_n, 1'b1)
      end
    end
    // Stop and drain before reprogramming, as host code must
    cc_debounce_enable = 0; line_control = 0; p1_lvl = exp1 & 7'h3e; exp1 = p1_lvl;
    for (k = 0; k < 50 && cc_debouncer_running_flag !== 1'b0; k++) tk(1);
    pin1_debounce_clear_enable = 7'h7e; role_sink = 0; line_control = 2'h1;
    cc_debounce_enable = 1; tk(40); p1_lvl = exp1 ^ 7'h41; exp1 ^= 7'h40;
    for (k = 0; k < 300 && pin1_threshold_match !== exp1; k++) tk(1);
    tk(30); // Host filters the match again before deciding
    `CHK(pin1_threshold_match, exp1)
    `CHK(source_detach, 1'b1)
    advertised_level = 2'h1; tk(2);
    `CHK(source_detach, exp1[1])
    advertised_level = 2'h2; tk(2);
    `CHK(source_detach, exp1[5])
    // Sink: CC status cleared before VBUS comes up
    pin1_change_clear = 7'h7f; role_sink = 1; bus_power_control = 1; vbus_on = 1;
    tk(1); pin1_change_clear = 0;
    for (k = 0; k < 300 && bus_power_threshold_match[0] !== 1'b1; k++) tk(1);
    tk(2);
    `CHK({bus_power_summary_irq, irq_n, source_connected, sink_pulldown_en}, 4'hb)
    `CHK({bus_power_threshold_match, bus_power_change_status}, 4'h7)
    bus_power_change_clear = 2'h3; tk(1); bus_power_change_clear = 0; vbus_on = 0;
    for (k = 0; k < 300 && bus_power_threshold_match[0] !== 1'b0; k++) tk(1);
    tk(2);
    `CHK({bus_power_change_status[0], irq_n}, 2'h2)
    // VCONN sits outside this block; power path is already open
    decay = 4'h5; discharge_request = 1; tk(1); discharge_request = 0; tk(1);
    `CHK(discharge_switch_closed, 1'b1)
    for (k = 0; k < 100 && discharge_switch_closed !== 1'b0; k++) tk(1);
    `CHK(discharge_error, 1'b0)
    summary_interrupt_enable = 3'h4; // Only the power summary may pull the pin now
    vbus_on = 1; tk(3); vbus_on = 0; decay = 0; discharge_request = 1; tk(1);
    discharge_request = 0;
    for (k = 0; k < 100 && discharge_error !== 1'b1; k++) tk(1);
    tk(2);
    `CHK({discharge_error, discharge_switch_closed, power_summary_irq, irq_n}, 4'ha)
    discharge_error_clear = 1; tk(1); discharge_error_clear = 0; tk(2);
    `CHK({discharge_error, irq_n}, 2'h1)
    stop_test();
  end
endmodule
